// ==== hw/aems_pkg.sv ====
// package: register map, field layout and carrier types of the error mask/severity/status block
package aems_pkg;

    // ========================================
    // register offsets (byte addresses)
    localparam logic [11:0] UNC_STATUS_OFS = 12'h104;
    localparam logic [11:0] UNC_MASK_OFS   = 12'h108;
    localparam logic [11:0] UNC_SEV_OFS    = 12'h10c;
    localparam logic [11:0] COR_STATUS_OFS = 12'h110;
    localparam logic [11:0] COR_MASK_OFS   = 12'h114;
    localparam logic [11:0] ERR_CTRL_OFS   = 12'h118;

    // ========================================
    // uncorrectable field positions
    localparam int UNC_TRAIN_BIT   = 0;
    localparam int UNC_DLPE_BIT    = 4;
    localparam int UNC_POISON_BIT  = 12;
    localparam int UNC_FCPE_BIT    = 13;
    localparam int UNC_CPL_TO_BIT  = 14;
    localparam int UNC_CA_BIT      = 15;
    localparam int UNC_UC_BIT      = 16;
    localparam int UNC_RX_OVF_BIT  = 17;
    localparam int UNC_MALF_BIT    = 18;
    localparam int UNC_ECRC_BIT    = 19;
    localparam int UNC_UR_BIT      = 20;
    localparam int UNC_ACS_BIT     = 21;

    // ========================================
    // correctable field positions
    localparam int COR_RX_ERR_BIT  = 0;
    localparam int COR_BAD_TLP_BIT = 6;
    localparam int COR_BAD_DLP_BIT = 7;
    localparam int COR_ROLL_BIT    = 8;
    localparam int COR_RPL_TO_BIT  = 12;
    localparam int COR_ADV_NF_BIT  = 13;

    // ========================================
    // implemented bits and reset values
    localparam logic [31:0] UNC_IMPL         = 32'h003ff011;
    localparam logic [31:0] SEV_IMPL         = 32'h00000011;
    localparam logic [31:0] COR_IMPL         = 32'h000031c1;
    localparam logic [31:0] UNC_STATUS_RESET = 32'h00000000;
    localparam logic [31:0] UNC_MASK_RESET   = 32'h00000000;
    localparam logic [31:0] UNC_SEV_RESET    = 32'h00000011;
    localparam logic [31:0] COR_STATUS_RESET = 32'h00000000;
    localparam logic [31:0] COR_MASK_RESET   = 32'h00002000;
    localparam logic [4:0]  FEP_RESET        = 5'h00;
    localparam int          FEP_LSB          = 0;

    // ========================================
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ========================================
    // carrier types
    typedef struct packed {
        logic [31:0] uncor;
        logic [31:0] cor;
    } aems_event_type;

    typedef struct packed {
        logic cor;
        logic nonfatal;
        logic fatal;
    } aems_msg_type;

    typedef struct packed {
        logic       strobe;
        logic       is_cor;
        logic [4:0] bit_pos;
    } aems_log_type;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } aems_wr_state_type;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } aems_rd_state_type;

endpackage : aems_pkg

// ==== hw/aems_top.sv ====
// error mask, severity and status registers of one switch port, reached over AXI4-Lite
// Functional notes
// - uncorrectable mask bit 0 blocks logging and messaging of training errors.
// - uncorrectable mask bit 4 blocks logging and messaging of link protocol errors.
// - uncorrectable mask bit 12 blocks logging and messaging of poisoned packets.
// - uncorrectable mask bit 13 blocks logging and messaging of flow control errors.
// - uncorrectable mask bit 14 blocks logging and messaging of completion timeouts.
// - uncorrectable mask bit 15 blocks logging and messaging of completer aborts.
// - uncorrectable mask bit 16 blocks logging and messaging of unexpected completions.
// - uncorrectable mask bit 17 blocks logging and messaging of receiver overflows.
// - uncorrectable mask bit 18 blocks logging and messaging of malformed packets.
// - uncorrectable mask bit 19 blocks logging and messaging of end-to-end CRC errors.
// - uncorrectable mask bit 20 blocks logging and messaging of unsupported requests.
// - severity bits 0 and 4 select fatal when one; both reset to one.
// - correctable status bit 0 sets on receiver error, resets zero, write-one clears.
// - correctable status bits 6 and 7 set on bad packets; reset zero.
// - correctable status bit 8 sets on replay counter rollover; resets zero.
// - correctable status bits 12 and 13 set on replay timeout, advisory error.
// - correctable mask bit 0 blocks logging and messaging of receiver errors.
// - correctable mask bits 6 and 7 block logging and messaging of bad packets.
// - correctable mask bit 8 blocks logging and messaging of replay rollovers.
// - correctable mask bit 12 blocks logging and messaging of replay timeouts.
// - correctable mask bit 13 blocks advisory errors and resets to one.
// - a first-error pointer holds the position of the first unmasked uncorrectable error.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module aems_top
    import aems_pkg::*;
(
    input  wire logic           REF_CLK,
    input  wire logic           RST_N,
    input  wire logic           SOFT_RST,
    input  wire aems_event_type EVENTS,
    output var  aems_msg_type   ERR_MSG,
    output var  aems_log_type   HDR_LOG,
    input  wire logic [11:0]    AWADDR,
    input  wire logic           AWVALID,
    output logic                AWREADY,
    input  wire logic [31:0]    WDATA,
    input  wire logic [3:0]     WSTRB,
    input  wire logic           WVALID,
    output logic                WREADY,
    output logic [1:0]          BRESP,
    output logic                BVALID,
    input  wire logic           BREADY,
    input  wire logic [11:0]    ARADDR,
    input  wire logic           ARVALID,
    output logic                ARREADY,
    output logic [31:0]         RDATA,
    output logic [1:0]          RRESP,
    output logic                RVALID,
    input  wire logic           RREADY
);

    // ========================================
    // state
    aems_wr_state_type wr_state;
    aems_rd_state_type rd_state;
    logic [11:0]       wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              have_aw;
    logic              have_w;
    logic [31:0]       unc_status;
    logic [31:0]       unc_mask;
    logic [31:0]       unc_sev;
    logic [31:0]       cor_status;
    logic [31:0]       cor_mask;
    logic [4:0]        first_err;

    // ========================================
    // combinational helpers
    logic [31:0] byte_mask;
    logic [31:0] unc_set;
    logic [31:0] cor_set;
    logic [31:0] unc_report;
    logic [31:0] cor_report;
    logic        wr_go;
    logic        wr_hit;
    logic [31:0] rd_word;
    logic        rd_hit;

    function automatic logic [4:0] lowest_set(input logic [31:0] v);
        logic [4:0] pos;
        pos = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                pos = 5'(i);
            end
        end
        return pos;
    endfunction : lowest_set

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            byte_mask[b*8 +: 8] = {8{wr_strb[b]}};
        end
    end

    assign wr_go  = (wr_state == WR_IDLE) && have_aw && have_w;

    always_comb begin
        case (wr_addr)
            UNC_STATUS_OFS, UNC_MASK_OFS, UNC_SEV_OFS,
            COR_STATUS_OFS, COR_MASK_OFS, ERR_CTRL_OFS: wr_hit = 1'b1;
            default:                                    wr_hit = 1'b0;
        endcase
    end

    assign unc_set = EVENTS.uncor & UNC_IMPL;
    assign cor_set = EVENTS.cor & COR_IMPL;

    assign unc_report = unc_set & ~unc_mask;

    assign cor_report = cor_set & ~cor_mask;

    // ========================================
    // write channel capture
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            have_aw <= 1'b0;
            wr_addr <= 12'h000;
            AWREADY <= 1'b0;
        end else if (SOFT_RST) begin
            have_aw <= 1'b0;
            AWREADY <= 1'b0;
        end else if (AWVALID && AWREADY) begin
            have_aw <= 1'b1;
            wr_addr <= {AWADDR[11:2], 2'b00};
            AWREADY <= 1'b0;
        end else if (wr_go) begin
            have_aw <= 1'b0;
        end else begin
            AWREADY <= !have_aw && (wr_state == WR_IDLE) && AWVALID;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            have_w  <= 1'b0;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            WREADY  <= 1'b0;
        end else if (SOFT_RST) begin
            have_w <= 1'b0;
            WREADY <= 1'b0;
        end else if (WVALID && WREADY) begin
            have_w  <= 1'b1;
            wr_data <= WDATA;
            wr_strb <= WSTRB;
            WREADY  <= 1'b0;
        end else if (wr_go) begin
            have_w <= 1'b0;
        end else begin
            WREADY <= !have_w && (wr_state == WR_IDLE) && WVALID;
        end
    end

    // ========================================
    // write response
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_state <= WR_IDLE;
            BVALID   <= 1'b0;
            BRESP    <= RESP_OKAY;
        end else if (SOFT_RST) begin
            wr_state <= WR_IDLE;
            BVALID   <= 1'b0;
        end else begin
            case (wr_state)
                WR_IDLE: begin
                    if (wr_go) begin
                        wr_state <= WR_RESP;
                        BVALID   <= 1'b1;
                        BRESP    <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (BREADY) begin
                        wr_state <= WR_IDLE;
                        BVALID   <= 1'b0;
                    end
                end
                default: begin
                    wr_state <= WR_IDLE;
                    BVALID   <= 1'b0;
                end
            endcase
        end
    end

    // ========================================
    // read channel
    // reserved bits read zero
    always_comb begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case ({ARADDR[11:2], 2'b00})
            UNC_STATUS_OFS: rd_word = unc_status;
            UNC_MASK_OFS:   rd_word = unc_mask;
            UNC_SEV_OFS:    rd_word = unc_sev;
            COR_STATUS_OFS: rd_word = cor_status;
            COR_MASK_OFS:   rd_word = cor_mask;
            ERR_CTRL_OFS:   rd_word = {27'h0, first_err};
            default:        rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_state <= RD_IDLE;
            ARREADY  <= 1'b0;
            RVALID   <= 1'b0;
            RDATA    <= 32'h00000000;
            RRESP    <= RESP_OKAY;
        end else if (SOFT_RST) begin
            rd_state <= RD_IDLE;
            ARREADY  <= 1'b0;
            RVALID   <= 1'b0;
        end else begin
            case (rd_state)
                RD_IDLE: begin
                    if (ARVALID && ARREADY) begin
                        rd_state <= RD_RESP;
                        ARREADY  <= 1'b0;
                        RVALID   <= 1'b1;
                        RDATA    <= rd_word;
                        RRESP    <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                    end else begin
                        ARREADY <= ARVALID;
                    end
                end
                RD_RESP: begin
                    if (RREADY) begin
                        rd_state <= RD_IDLE;
                        RVALID   <= 1'b0;
                    end
                end
                default: begin
                    rd_state <= RD_IDLE;
                    ARREADY  <= 1'b0;
                    RVALID   <= 1'b0;
                end
            endcase
        end
    end

    // ========================================
    // uncorrectable mask
    // only power reset clears, reserved bits held zero
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            unc_mask <= UNC_MASK_RESET;
        end else if (wr_go && (wr_addr == UNC_MASK_OFS)) begin
            unc_mask <= ((unc_mask & ~byte_mask) | (wr_data & byte_mask)) & UNC_IMPL;
        end
    end

    // ========================================
    // uncorrectable severity
    // severity select written
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            unc_sev <= UNC_SEV_RESET;
        end else if (wr_go && (wr_addr == UNC_SEV_OFS)) begin
            unc_sev <= ((unc_sev & ~byte_mask) | (wr_data & byte_mask)) & SEV_IMPL;
        end
    end

    // ========================================
    // correctable mask
    // advisory mask writable
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cor_mask <= COR_MASK_RESET;
        end else if (wr_go && (wr_addr == COR_MASK_OFS)) begin
            cor_mask <= ((cor_mask & ~byte_mask) | (wr_data & byte_mask)) & COR_IMPL;
        end
    end

    // ========================================
    // sticky status, set wins over clear
    // write one clears
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cor_status <= COR_STATUS_RESET;
        end else if (wr_go && (wr_addr == COR_STATUS_OFS)) begin
            cor_status <= (cor_status & ~(wr_data & byte_mask)) | cor_set;
        end else begin
            cor_status <= cor_status | cor_set;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            unc_status <= UNC_STATUS_RESET;
        end else if (wr_go && (wr_addr == UNC_STATUS_OFS)) begin
            unc_status <= (unc_status & ~(wr_data & byte_mask)) | unc_set;
        end else begin
            unc_status <= unc_status | unc_set;
        end
    end

    // ========================================
    // first error pointer
    // capture when previous error cleared
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            first_err <= FEP_RESET;
        end else if (!unc_status[first_err] && (|unc_report)) begin
            first_err <= lowest_set(unc_report);
        end
    end

    // ========================================
    // error messages
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ERR_MSG <= '0;
        end else begin
            ERR_MSG.fatal    <= |(unc_report & unc_sev);
            ERR_MSG.nonfatal <= |(unc_report & ~unc_sev);
            ERR_MSG.cor      <= |cor_report;
        end
    end

    // ========================================
    // header log strobe
    // only unmasked errors logged
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            HDR_LOG <= '0;
        end else begin
            HDR_LOG.strobe   <= (|unc_report) || (|cor_report);
            HDR_LOG.is_cor   <= !(|unc_report);
            HDR_LOG.bit_pos  <= (|unc_report) ? lowest_set(unc_report) : lowest_set(cor_report);
        end
    end

endmodule : aems_top

`default_nettype wire

// ==== tb/aems_sva.sv ====
// port-level checks of the error mask, severity and status block
`timescale 1ns/10ps
`default_nettype none
module aems_sva
    import aems_pkg::*;
(
    input wire logic           REF_CLK,
    input wire logic           RST_N,
    input wire logic           SOFT_RST,
    input wire aems_event_type EVENTS,
    input wire aems_msg_type   ERR_MSG,
    input wire aems_log_type   HDR_LOG,
    input wire logic           AWVALID,
    input wire logic           AWREADY,
    input wire logic           WVALID,
    input wire logic           WREADY,
    input wire logic [1:0]     BRESP,
    input wire logic           BVALID,
    input wire logic           BREADY,
    input wire logic           ARVALID,
    input wire logic           ARREADY,
    input wire logic [31:0]    RDATA,
    input wire logic [1:0]     RRESP,
    input wire logic           RVALID,
    input wire logic           RREADY
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);
    // ========================================
    // error reporting
    chk_unc_cause: assert property (
        (ERR_MSG.fatal || ERR_MSG.nonfatal) |-> |($past(EVENTS.uncor) & UNC_IMPL))
        else $error("uncorrectable message without event");
    chk_cor_cause: assert property (
        ERR_MSG.cor |-> |($past(EVENTS.cor) & COR_IMPL))
        else $error("correctable message without event");
    chk_log_pair: assert property (
        HDR_LOG.strobe == (ERR_MSG != 3'h0))
        else $error("log capture and message disagree");
    chk_log_kind: assert property (
        (HDR_LOG.strobe && HDR_LOG.is_cor) |-> (ERR_MSG.cor && !ERR_MSG.fatal && !ERR_MSG.nonfatal))
        else $error("correctable log with uncorrectable message");
    // ========================================
    // register access
    chk_wr_answer: assert property (
        (AWVALID && AWREADY && WVALID && WREADY) |-> ##[1:3] BVALID)
        else $error("write response missing");
    chk_b_hold: assert property (
        (BVALID && !BREADY) |=> (BVALID && $stable(BRESP)))
        else $error("write response dropped");
    chk_rd_answer: assert property (
        (ARVALID && ARREADY) |=> RVALID)
        else $error("read data late");
    chk_r_hold: assert property (
        (RVALID && !RREADY) |=> (RVALID && $stable(RDATA) && $stable(RRESP)))
        else $error("read data dropped");
    chk_soft_quiet: assert property (
        SOFT_RST |=> !(AWREADY || WREADY || ARREADY || BVALID || RVALID))
        else $error("handshake alive after soft reset");
endmodule : aems_sva
`default_nettype wire

// ==== tb/aems_rc_model.sv ====
// root complex stand-in counting error messages and header log captures
`timescale 1ns/10ps
`default_nettype none
module aems_rc_model
    import aems_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire aems_msg_type msg,
    input  wire aems_log_type log_req,
    output var  int           msg_count,
    output var  int           log_count
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_count <= 0;
        end else begin
            msg_count <= msg_count + $countones(msg);
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            log_count <= 0;
        end else begin
            log_count <= log_count + int'(log_req.strobe);
        end
    end
endmodule : aems_rc_model
`default_nettype wire

// ==== tb/aems_top_test.sv ====
// self-checking bench of the error mask, severity and status block
`timescale 1ns/10ps
`default_nettype none
module aems_top_test
    import aems_pkg::*;
;
    logic           ref_clk = 0, rst_n = 0, soft_rst = 0;
    aems_event_type events  = '0;
    logic [11:0]    awaddr  = '0, araddr = '0;
    logic [31:0]    wdata   = '0, rd;
    logic [3:0]     wstrb   = '0;
    logic           awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic           awready, wready, bvalid, arready, rvalid;
    logic [1:0]     bresp, rresp, rs;
    logic [31:0]    rdata;
    aems_msg_type   err_msg;
    aems_log_type   hdr_log;
    int             num_errors = 0, tests_run = 0, exp_msgs = 0, msg_count, log_count;
    // rows: correctable flag, bit position, expected message when unmasked
    logic [8:0]     rows [18] = '{{1'b0,5'd0,3'd1}, {1'b0,5'd4,3'd1}, {1'b0,5'd12,3'd2}, {1'b0,5'd13,3'd2},
        {1'b0,5'd14,3'd2}, {1'b0,5'd15,3'd2}, {1'b0,5'd16,3'd2}, {1'b0,5'd17,3'd2}, {1'b0,5'd18,3'd2},
        {1'b0,5'd19,3'd2}, {1'b0,5'd20,3'd2}, {1'b0,5'd21,3'd2}, {1'b1,5'd0,3'd4}, {1'b1,5'd6,3'd4},
        {1'b1,5'd7,3'd4}, {1'b1,5'd8,3'd4}, {1'b1,5'd12,3'd4}, {1'b1,5'd13,3'd4}};
    logic [11:0]    rst_addr [4] = '{UNC_MASK_OFS, UNC_SEV_OFS, COR_STATUS_OFS, COR_MASK_OFS};
    logic [31:0]    rst_exp  [4] = '{32'h00000000, 32'h00000011, 32'h00000000, 32'h00002000};

    always #12.5 ref_clk = ~ref_clk;

    aems_top uut (.REF_CLK(ref_clk), .RST_N(rst_n), .SOFT_RST(soft_rst), .EVENTS(events), .ERR_MSG(err_msg),
        .HDR_LOG(hdr_log), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
        .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
    aems_rc_model rc (.clk(ref_clk), .rst_n(rst_n), .msg(err_msg), .log_req(hdr_log), .msg_count(msg_count),
        .log_count(log_count));

    // ========================================
    // compare, bus and event tasks
    task check_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : check_val
    task check_out(input aems_msg_type m, input logic s, input logic c, input logic [4:0] p);
        tests_run++;
        if (err_msg !== m || hdr_log.strobe !== s || (s && {hdr_log.is_cor, hdr_log.bit_pos} !== {c, p})) begin
            num_errors++;
            $display("ERROR %0t report %b log %b expected %b", $time, err_msg, hdr_log, m);
        end
    endtask : check_out
    task axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (!aw_done && awready) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr
    task axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd
    task pulse(input logic c, input logic [4:0] p);
        @(posedge ref_clk);
        if (c) events.cor[p] <= 1'b1;
        else events.uncor[p] <= 1'b1;
        @(posedge ref_clk);
        events <= '0;
        #1;
    endtask : pulse
    task report_and_stop;
        $display("mismatches %0d comparisons %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // ========================================
    // main sequence
    initial begin
        logic [11:0] ma, sa;
        logic [4:0]  p;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            axi_rd(rst_addr[i], rd, rs);
            check_val(rd, rst_exp[i]);
        end
        pulse(1'b1, 5'd13);
        check_out(3'h0, 1'b0, 1'b0, 5'd0);
        axi_rd(COR_STATUS_OFS, rd, rs);
        check_val(rd, 32'h00002000);
        axi_wr(COR_STATUS_OFS, 32'h00002000, rs);
        for (int i = 0; i < 18; i++) begin
            p = rows[i][7:3];
            ma = rows[i][8] ? COR_MASK_OFS : UNC_MASK_OFS;
            sa = rows[i][8] ? COR_STATUS_OFS : UNC_STATUS_OFS;
            axi_wr(ma, 32'h0, rs);
            pulse(rows[i][8], p);
            check_out(rows[i][2:0], 1'b1, rows[i][8], p);
            exp_msgs++;
            axi_rd(sa, rd, rs);
            check_val(rd, 32'h1 << p);
            axi_wr(sa, 32'h1 << p, rs);
            axi_rd(sa, rd, rs);
            check_val(rd, 32'h0);
            axi_wr(ma, 32'h1 << p, rs);
            axi_rd(ma, rd, rs);
            check_val(rd, 32'h1 << p);
            pulse(rows[i][8], p);
            check_out(3'h0, 1'b0, 1'b0, 5'd0);
            axi_wr(sa, 32'h1 << p, rs);
        end
        axi_wr(UNC_MASK_OFS, 32'h0, rs);
        axi_wr(UNC_SEV_OFS, 32'h0, rs);
        pulse(1'b0, 5'd4);
        check_out(3'h2, 1'b1, 1'b0, 5'd4);
        exp_msgs++;
        pulse(1'b0, 5'd12);
        check_out(3'h2, 1'b1, 1'b0, 5'd12);
        exp_msgs++;
        axi_rd(ERR_CTRL_OFS, rd, rs);
        check_val(rd, 32'h00000004);
        axi_wr(UNC_STATUS_OFS, 32'h1010, rs);
        axi_wr(UNC_MASK_OFS, 32'hffffffff, rs);
        axi_wr(UNC_SEV_OFS, 32'hffffffff, rs);
        @(posedge ref_clk);
        soft_rst <= 1'b1;
        @(posedge ref_clk);
        soft_rst <= 1'b0;
        axi_rd(UNC_MASK_OFS, rd, rs);
        check_val(rd, 32'h003ff011);
        axi_rd(UNC_SEV_OFS, rd, rs);
        check_val(rd, 32'h00000011);
        axi_wr(12'h200, 32'hffffffff, rs);
        check_val(32'(rs), 32'(RESP_SLVERR));
        axi_rd(12'h200, rd, rs);
        check_val({rd[29:0], rs}, {30'h0, RESP_SLVERR});
        check_val(msg_count, exp_msgs);
        check_val(log_count, exp_msgs);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        axi_rd(UNC_MASK_OFS, rd, rs);
        check_val(rd, 32'h00000000);
        report_and_stop();
    end

    initial begin
        #400000;
        num_errors++;
        report_and_stop();
    end
endmodule : aems_top_test

bind aems_top aems_sva chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .SOFT_RST(SOFT_RST), .EVENTS(EVENTS),
    .ERR_MSG(ERR_MSG), .HDR_LOG(HDR_LOG), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
`default_nettype wire
